/* include/dds_pkg.sv */
`default_nettype none
package dds_pkg;
   localparam int CLK_HZ     = 250_000_000;
   localparam int TIMEOUT_MS = 250;
   // Longest wait, rounded down to whole cycles
   localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int OVERSAMPLE  = 16;
   localparam int SYS_MAX     = 256;
   localparam int FIFO_DEPTH  = 8;
   localparam int FIFO_WIDTH  = 25;

   // Register word addresses within the sixteen-address group
   localparam logic [3:0] A_TXDATA  = 4'h0;
   localparam logic [3:0] A_TXSPEED = 4'h1;
   localparam logic [3:0] A_RXSPEED = 4'h2;
   localparam logic [3:0] A_STARTCH = 4'h3;
   localparam logic [3:0] A_COUNT   = 4'h4;
   localparam logic [3:0] A_SYSADDR = 4'h5;
   localparam logic [3:0] A_DATADDR = 4'h6;
   localparam logic [3:0] A_CTRL    = 4'h7;
   localparam logic [3:0] A_STATUS  = 4'h8;

   // Control and status bit positions
   localparam int CTRL_SYS_EN  = 0;
   localparam int CTRL_DATA_EN = 1;
   localparam int ST_TX_READY  = 0;
   localparam int ST_OVERRUN   = 1;
   localparam int ST_FRAME_ERR = 2;
   localparam int ST_DATA_MODE = 3;
   localparam int ST_SYS_CAUSE = 4;
   localparam int ST_DAT_CAUSE = 8;

   // Values after reset
   localparam logic [15:0] RST_SPEED = 16'h065B;
   localparam logic [7:0]  RST_START = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] RST_ADDR  = 16'h0000;
   localparam logic [1:0]  RST_CTRL  = 2'h0;

   typedef enum logic [1:0] {
      DDS_MSG_IDLE = 2'b00,
      DDS_MSG_SYS  = 2'b01,
      DDS_MSG_DATA = 2'b10
   } dds_msg_t;

   typedef enum logic [2:0] {
      DDS_END_NONE     = 3'b000,
      DDS_END_TIMEOUT  = 3'b001,
      DDS_END_COUNT    = 3'b010,
      DDS_END_OVERFLOW = 3'b011,
      DDS_END_START    = 3'b100
   } dds_cause_t;

   typedef enum logic [1:0] {
      DDS_RX_IDLE  = 2'b00,
      DDS_RX_START = 2'b01,
      DDS_RX_DATA  = 2'b10,
      DDS_RX_STOP  = 2'b11
   } dds_rx_t;
endpackage
`default_nettype wire

/* rtl/dds_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module dds_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      level_reg;
   logic             push;
   logic             pop;

   // Full and empty follow the true fill level
   assign in_ready  = (level_reg != (AW+1)'(DEPTH));
   assign out_valid = (level_reg != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_reg];

   // Storage has no reset, only the pointers and the fill level need one
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            level_reg <= level_reg + 1'b1;
         end else if (pop && !push) begin
            level_reg <= level_reg - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/dds_rx.sv */
`timescale 1ns/1ns
`default_nettype none
module dds_rx (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       tick16,
   input  wire logic       rxd,
   output logic            byte_valid,
   output logic [7:0]      byte_data,
   output logic            frame_err
);
   dds_pkg::dds_rx_t st_reg;
   logic [3:0]       tick_cnt_reg;
   logic [2:0]       bit_cnt_reg;
   logic [7:0]       shift_reg;

   // Bit timing on the 16x enable, sampling at mid-bit
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg       <= dds_pkg::DDS_RX_IDLE;
         tick_cnt_reg <= 4'h0;
         bit_cnt_reg  <= 3'h0;
         shift_reg    <= 8'h00;
         byte_valid   <= 1'b0;
         byte_data    <= 8'h00;
         frame_err    <= 1'b0;
      end else begin
         byte_valid <= 1'b0;
         frame_err  <= 1'b0;
         if (tick16) begin
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
            case (st_reg)
               dds_pkg::DDS_RX_IDLE: begin
                  tick_cnt_reg <= 4'h0;
                  if (!rxd) begin
                     st_reg <= dds_pkg::DDS_RX_START;
                  end
               end
               dds_pkg::DDS_RX_START: begin
                  // Half a bit in: glitch rejection on the start bit
                  if (tick_cnt_reg == 4'h7) begin
                     tick_cnt_reg <= 4'h0;
                     bit_cnt_reg  <= 3'h0;
                     st_reg       <= rxd ? dds_pkg::DDS_RX_IDLE : dds_pkg::DDS_RX_DATA;
                  end
               end
               dds_pkg::DDS_RX_DATA: begin
                  if (tick_cnt_reg == 4'hF) begin
                     shift_reg   <= {rxd, shift_reg[7:1]};
                     bit_cnt_reg <= bit_cnt_reg + 3'h1;
                     if (bit_cnt_reg == 3'h7) begin
                        st_reg <= dds_pkg::DDS_RX_STOP;
                     end
                  end
               end
               dds_pkg::DDS_RX_STOP: begin
                  if (tick_cnt_reg == 4'hF) begin
                     st_reg     <= dds_pkg::DDS_RX_IDLE;
                     byte_valid <= rxd;
                     byte_data  <= shift_reg;
                     frame_err  <= !rxd;
                  end
               end
               default: begin
                  st_reg <= dds_pkg::DDS_RX_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/dds_top.sv */
`timescale 1ns/1ns
`default_nettype none
module dds_top #(
   parameter int TIMEOUT_CYC = dds_pkg::TIMEOUT_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic [3:0]  wr_addr,
   input  wire logic [15:0] wr_data,
   input  wire logic [3:0]  rd_addr,
   output logic      [15:0] rd_data,
   input  wire logic        rxd_pin,
   output logic             txd_pin,
   output logic             dma_valid,
   input  wire logic        dma_ready,
   output logic             dma_chan,
   output logic      [15:0] dma_addr,
   output logic      [7:0]  dma_data,
   output logic             irq_sys,
   output logic             irq_data
);
   // Host-visible registers
   logic [15:0]         tx_speed_reg;
   logic [15:0]         rx_speed_reg;
   logic [7:0]          start_reg;
   logic [15:0]         count_reg;
   logic [15:0]         sys_addr_reg;
   logic [15:0]         dat_addr_reg;
   logic [1:0]          ctrl_reg;
   logic                overrun_reg;
   logic                ferr_reg;
   dds_pkg::dds_cause_t sys_cause_reg;
   dds_pkg::dds_cause_t dat_cause_reg;

   // Transmit store
   logic       hold_full_reg;
   logic [7:0] hold_reg;
   logic       buf_full_reg;
   logic [7:0] buf_reg;
   logic       tx_busy_reg;
   logic [9:0] tx_shift_reg;
   logic [3:0] tx_tick_reg;
   logic [3:0] tx_bit_reg;

   // Receive path
   logic             rxd_meta_reg;
   logic             rxd_sync_reg;
   logic             rx_valid;
   logic [7:0]       rx_byte;
   logic             rx_ferr;
   dds_pkg::dds_msg_t msg_reg;
   logic [8:0]       sys_cnt_reg;
   logic [15:0]      dat_cnt_reg;
   logic [15:0]      sys_ptr_reg;
   logic [15:0]      dat_ptr_reg;
   logic [31:0]      idle_reg;
   logic             timeout;
   logic             is_start;
   logic             end_sys;
   logic             end_dat;
   dds_pkg::dds_cause_t sys_cause_next;
   dds_pkg::dds_cause_t dat_cause_next;
   logic [15:0]      sys_ptr_next;
   logic [8:0]       sys_cnt_next;
   logic [15:0]      dat_cnt_next;
   logic             push;
   logic             push_chan;
   logic [15:0]      push_addr;
   logic             fifo_in_ready;
   logic [24:0]      fifo_out;
   logic [1:0]       tick16;

   // One address of the sixteen-word group
   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction

   // Register writes for the settings; transmit data and status writes are decoded where they act
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_speed_reg <= dds_pkg::RST_SPEED;
         rx_speed_reg <= dds_pkg::RST_SPEED;
         start_reg    <= dds_pkg::RST_START;
         count_reg    <= dds_pkg::RST_COUNT;
         sys_addr_reg <= dds_pkg::RST_ADDR;
         dat_addr_reg <= dds_pkg::RST_ADDR;
         ctrl_reg     <= dds_pkg::RST_CTRL;
      end else if (wr_en) begin
         if (hit(wr_addr, dds_pkg::A_TXSPEED)) tx_speed_reg <= wr_data;
         if (hit(wr_addr, dds_pkg::A_RXSPEED)) rx_speed_reg <= wr_data;
         if (hit(wr_addr, dds_pkg::A_STARTCH)) start_reg <= wr_data[7:0];
         if (hit(wr_addr, dds_pkg::A_COUNT)) count_reg <= wr_data;
         if (hit(wr_addr, dds_pkg::A_SYSADDR)) sys_addr_reg <= wr_data;
         if (hit(wr_addr, dds_pkg::A_DATADDR)) dat_addr_reg <= wr_data;
         if (hit(wr_addr, dds_pkg::A_CTRL)) ctrl_reg <= wr_data[1:0];
      end
   end

   // Read-back is registered; unused addresses read zero
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_data <= 16'h0000;
      end else begin
         case (rd_addr)
            dds_pkg::A_TXSPEED: rd_data <= tx_speed_reg;
            dds_pkg::A_RXSPEED: rd_data <= rx_speed_reg;
            dds_pkg::A_STARTCH: rd_data <= {8'h00, start_reg};
            dds_pkg::A_COUNT:   rd_data <= count_reg;
            dds_pkg::A_SYSADDR: rd_data <= sys_addr_reg;
            dds_pkg::A_DATADDR: rd_data <= dat_addr_reg;
            dds_pkg::A_CTRL:    rd_data <= {14'h0000, ctrl_reg};
            dds_pkg::A_STATUS: begin
               rd_data <= {5'h00, dat_cause_reg, 1'b0, sys_cause_reg,
                           msg_reg == dds_pkg::DDS_MSG_DATA, ferr_reg,
                           overrun_reg, !hold_full_reg};
            end
            default: rd_data <= 16'h0000;
         endcase
      end
   end

   // Two 16x rate dividers, transmit and receive set separately
   generate
      for (genvar g = 0; g < 2; g++) begin : g_div
         logic [15:0] cnt_reg;
         logic [15:0] div;
         assign div = (g == 0) ? tx_speed_reg : rx_speed_reg;
         always_ff @(posedge mclk) begin
            if (rst) begin
               cnt_reg   <= 16'h0000;
               tick16[g] <= 1'b0;
            end else if (cnt_reg + 16'h0001 >= div) begin
               cnt_reg   <= 16'h0000;
               tick16[g] <= 1'b1;
            end else begin
               cnt_reg   <= cnt_reg + 16'h0001;
               tick16[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Holding register: a write while full is dropped
   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_full_reg <= 1'b0;
         hold_reg      <= 8'h00;
      end else if (wr_en && hit(wr_addr, dds_pkg::A_TXDATA) && !hold_full_reg) begin
         hold_full_reg <= 1'b1;
         hold_reg      <= wr_data[7:0];
      end else if (hold_full_reg && !buf_full_reg) begin
         hold_full_reg <= 1'b0;
      end
   end

   // Transmit buffer, second stage of the three-byte store
   always_ff @(posedge mclk) begin
      if (rst) begin
         buf_full_reg <= 1'b0;
         buf_reg      <= 8'h00;
      end else if (hold_full_reg && !buf_full_reg) begin
         buf_full_reg <= 1'b1;
         buf_reg      <= hold_reg;
      end else if (buf_full_reg && !tx_busy_reg) begin
         buf_full_reg <= 1'b0;
      end
   end

   // Shifter, 8N1; idle line rests at one
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_busy_reg  <= 1'b0;
         tx_shift_reg <= 10'h3FF;
         tx_tick_reg  <= 4'h0;
         tx_bit_reg   <= 4'h0;
      end else if (!tx_busy_reg) begin
         if (buf_full_reg) begin
            tx_busy_reg  <= 1'b1;
            tx_shift_reg <= {1'b1, buf_reg, 1'b0};
            tx_tick_reg  <= 4'h0;
            tx_bit_reg   <= 4'h0;
         end
      end else if (tick16[0]) begin
         tx_tick_reg <= tx_tick_reg + 4'h1;
         if (tx_tick_reg == 4'hF) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_bit_reg   <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == 4'h9) begin
               tx_busy_reg <= 1'b0;
            end
         end
      end
   end
   assign txd_pin = tx_shift_reg[0];

   // Line input crosses in through two flops
   always_ff @(posedge mclk) begin
      if (rst) begin
         rxd_meta_reg <= 1'b1;
         rxd_sync_reg <= 1'b1;
      end else begin
         rxd_meta_reg <= rxd_pin;
         rxd_sync_reg <= rxd_meta_reg;
      end
   end

   dds_rx u_rx (
      .mclk       (mclk),
      .rst        (rst),
      .tick16     (tick16[1]),
      .rxd        (rxd_sync_reg),
      .byte_valid (rx_valid),
      .byte_data  (rx_byte),
      .frame_err  (rx_ferr)
   );

   // Idle time since the last character, saturating
   always_ff @(posedge mclk) begin
      if (rst || rx_valid) begin
         idle_reg <= 32'h0000_0000;
      end else if (idle_reg <= 32'(TIMEOUT_CYC)) begin
         idle_reg <= idle_reg + 32'h0000_0001;
      end
   end
   assign timeout = (idle_reg == 32'(TIMEOUT_CYC)) && !rx_valid;

   // Message decisions for the character of this cycle
   always_comb begin
      is_start       = (rx_byte == start_reg);
      sys_ptr_next   = (msg_reg == dds_pkg::DDS_MSG_SYS) ? sys_ptr_reg : sys_addr_reg;
      sys_cnt_next   = (msg_reg == dds_pkg::DDS_MSG_SYS) ? sys_cnt_reg + 9'h001 : 9'h001;
      dat_cnt_next   = dat_cnt_reg + 16'h0001;
      end_sys        = 1'b0;
      end_dat        = 1'b0;
      sys_cause_next = dds_pkg::DDS_END_NONE;
      dat_cause_next = dds_pkg::DDS_END_NONE;
      push           = 1'b0;
      push_chan      = 1'b0;
      push_addr      = sys_ptr_next;
      if (rx_valid) begin
         if (msg_reg == dds_pkg::DDS_MSG_DATA) begin
            push      = ctrl_reg[dds_pkg::CTRL_DATA_EN];
            push_chan = 1'b1;
            push_addr = dat_ptr_reg;
            if (dat_cnt_next == count_reg) begin
               end_dat        = 1'b1;
               dat_cause_next = dds_pkg::DDS_END_COUNT;
            end
         end else if (is_start) begin
            end_sys        = (msg_reg == dds_pkg::DDS_MSG_SYS);
            sys_cause_next = dds_pkg::DDS_END_START;
         end else begin
            push = ctrl_reg[dds_pkg::CTRL_SYS_EN];
            if (sys_cnt_next == 9'(dds_pkg::SYS_MAX)) begin
               end_sys        = 1'b1;
               sys_cause_next = dds_pkg::DDS_END_OVERFLOW;
            end
         end
      end else if (timeout) begin
         end_sys        = (msg_reg == dds_pkg::DDS_MSG_SYS);
         end_dat        = (msg_reg == dds_pkg::DDS_MSG_DATA);
         sys_cause_next = dds_pkg::DDS_END_TIMEOUT;
         dat_cause_next = dds_pkg::DDS_END_TIMEOUT;
      end
   end

   // Message state and character counts
   always_ff @(posedge mclk) begin
      if (rst) begin
         msg_reg     <= dds_pkg::DDS_MSG_IDLE;
         sys_cnt_reg <= 9'h000;
         dat_cnt_reg <= 16'h0000;
      end else if (rx_valid) begin
         if (msg_reg == dds_pkg::DDS_MSG_DATA) begin
            dat_cnt_reg <= dat_cnt_next;
            if (end_dat) msg_reg <= dds_pkg::DDS_MSG_IDLE;
         end else if (is_start) begin
            msg_reg     <= dds_pkg::DDS_MSG_DATA;
            dat_cnt_reg <= 16'h0000;
         end else begin
            sys_cnt_reg <= sys_cnt_next;
            msg_reg     <= end_sys ? dds_pkg::DDS_MSG_IDLE : dds_pkg::DDS_MSG_SYS;
         end
      end else if (end_sys || end_dat) begin
         msg_reg <= dds_pkg::DDS_MSG_IDLE;
      end
   end

   // Store pointers advance on each character of an enabled channel, even one a full queue loses
   always_ff @(posedge mclk) begin
      if (rst) begin
         sys_ptr_reg <= dds_pkg::RST_ADDR;
         dat_ptr_reg <= dds_pkg::RST_ADDR;
      end else if (rx_valid) begin
         if (msg_reg != dds_pkg::DDS_MSG_DATA && is_start) begin
            dat_ptr_reg <= dat_addr_reg;
         end else if (msg_reg == dds_pkg::DDS_MSG_DATA) begin
            if (push) dat_ptr_reg <= dat_ptr_reg + 16'h0001;
         end else begin
            sys_ptr_reg <= push ? sys_ptr_next + 16'h0001 : sys_ptr_next;
         end
      end
   end

   // Per-channel end pulses and the cause of the last end
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_sys       <= 1'b0;
         irq_data      <= 1'b0;
         sys_cause_reg <= dds_pkg::DDS_END_NONE;
         dat_cause_reg <= dds_pkg::DDS_END_NONE;
      end else begin
         irq_sys  <= end_sys;
         irq_data <= end_dat;
         if (end_sys) sys_cause_reg <= sys_cause_next;
         if (end_dat) dat_cause_reg <= dat_cause_next;
      end
   end

   // Sticky errors; a new event beats a same-cycle clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         overrun_reg <= 1'b0;
         ferr_reg    <= 1'b0;
      end else begin
         if (push && !fifo_in_ready) begin
            overrun_reg <= 1'b1;
         end else if (wr_en && hit(wr_addr, dds_pkg::A_STATUS)) begin
            overrun_reg <= 1'b0;
         end
         if (rx_ferr) begin
            ferr_reg <= 1'b1;
         end else if (wr_en && hit(wr_addr, dds_pkg::A_STATUS)) begin
            ferr_reg <= 1'b0;
         end
      end
   end

   // Line cannot be stalled, so a full queue loses the character
   dds_fifo #(
      .WIDTH (dds_pkg::FIFO_WIDTH),
      .DEPTH (dds_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   ({push_chan, push_addr, rx_byte}),
      .out_valid (dma_valid),
      .out_ready (dma_ready),
      .out_data  (fifo_out)
   );
   assign dma_chan = fifo_out[24];
   assign dma_addr = fifo_out[23:8];
   assign dma_data = fifo_out[7:0];
endmodule
`default_nettype wire

/* tb/dds_peer.sv */
`timescale 1ns/1ns
`default_nettype none
// Far-end line partner; its line idles high between frames
module dds_peer #(
   parameter int BIT = 16
) (
   input  wire logic mclk,
   input  wire logic txd,
   output logic      rxd
);
   logic [7:0] got;
   int         got_n = 0;
   initial rxd = 1'b1;
   // One 8N1 character, low bit first
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT) @(posedge mclk);
      end
   endtask
   // Sample mid-bit; a bad stop bit is not counted
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT) @(posedge mclk);
         if (i < 8) got[i] = txd;
         else if (txd === 1'b1) got_n++;
      end
   end
endmodule
`default_nettype wire

/* tb/dds_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module dds_top_asserts #(
   parameter int TIMEOUT_CYC = 2000
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        wr_en,
   input wire logic [3:0]  wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [3:0]  rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic        txd_pin,
   input wire logic        dma_valid,
   input wire logic        dma_ready,
   input wire logic        dma_chan,
   input wire logic [15:0] dma_addr,
   input wire logic [7:0]  dma_data,
   input wire logic        irq_sys,
   input wire logic        irq_data
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Divider write followed by a read of the same place
   sequence s_speed_load;
      wr_en && wr_addr == dds_pkg::A_RXSPEED ##1 rd_addr == dds_pkg::A_RXSPEED && !wr_en;
   endsequence
   a_rst_quiet: assert property (disable iff (1'b0) rst |=> txd_pin && !dma_valid && !irq_sys && !irq_data && rd_data == 16'h0000) else $error("outputs not quiet in reset");
   a_sys_irq_pulse: assert property (irq_sys |=> !irq_sys) else $error("system irq too long");
   a_data_irq_pulse: assert property (irq_data |=> !irq_data) else $error("data irq too long");
   a_dma_stall_hold: assert property (dma_valid && !dma_ready |=> dma_valid && $stable(dma_addr) && $stable(dma_data) && $stable(dma_chan)) else $error("dma word moved while stalled");
   a_speed_readback: assert property (s_speed_load |=> rd_data == $past(wr_data, 2)) else $error("speed not held");
   a_reset_speed: assert property ($fell(rst) && rd_addr == dds_pkg::A_TXSPEED && !wr_en |=> rd_data == dds_pkg::RST_SPEED) else $error("speed reset value");
   a_unmapped_zero: assert property (rd_addr > dds_pkg::A_STATUS |=> rd_data == 16'h0000) else $error("unmapped read not zero");
   a_start_bit_len: assert property ($fell(txd_pin) |-> !txd_pin [*8]) else $error("start bit too short");
endmodule
`default_nettype wire

/* tb/tb_dual_dma_serial_receiver.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_dual_dma_serial_receiver;
   localparam int TO = 300;
   logic        mclk = 1'b0;
   logic        rst, wr_en, dma_ready, rxd_pin, txd_pin, dma_valid, dma_chan;
   logic        irq_sys, irq_data, stall;
   logic [3:0]  wr_addr, rd_addr;
   logic [15:0] wr_data, rd_data, dma_addr;
   logic [7:0]  dma_data;
   logic [24:0] q[$];
   int          failures = 0, checks_done = 0, qn = 0, n_sys = 0, n_dat = 0, b;
   logic [7:0]  m1[6] = '{8'h11, 8'h22, 8'hA5, 8'h33, 8'h44, 8'h55};
   dds_top #(.TIMEOUT_CYC(TO)) uut (.mclk(mclk), .rst(rst), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
      .rxd_pin(rxd_pin), .txd_pin(txd_pin), .dma_valid(dma_valid), .dma_ready(dma_ready),
      .dma_chan(dma_chan), .dma_addr(dma_addr), .dma_data(dma_data), .irq_sys(irq_sys),
      .irq_data(irq_data));
   dds_peer #(.BIT(16)) peer (.mclk(mclk), .txd(txd_pin), .rxd(rxd_pin));
   always #2 mclk = ~mclk;
   // Host side takes every other cycle, or none while stalling
   always @(posedge mclk) begin
      dma_ready <= (stall || rst) ? 1'b0 : ~dma_ready;
      if (dma_valid === 1'b1 && dma_ready === 1'b1) q.push_back({dma_chan, dma_addr, dma_data});
      qn = q.size();
      if (irq_sys === 1'b1) n_sys++;
      if (irq_data === 1'b1) n_dat++;
   end
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string w, input logic [24:0] seen, input logic [24:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
      @(posedge mclk);
   endtask
   // Read data is registered, so it is valid one edge after the address
   task automatic rchk(input string w, input logic [3:0] a, input logic [15:0] m,
                       input logic [15:0] e);
      rd_addr <= a;
      repeat (2) @(posedge mclk);
      check(w, rd_data & m, e);
   endtask
   // Bounded wait on a counter kept by the monitor
   task automatic wait_for(ref int cnt, input int want);
      for (int i = 0; i < 2000 && cnt < want; i++) @(posedge mclk);
      if (cnt < want) begin
         failures++;
         report_and_stop();
      end
   endtask
   initial begin
      {rst, stall} = 2'b10;
      {wr_en, wr_addr, wr_data} = '0;
      rd_addr = dds_pkg::A_TXSPEED;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rchk("tx speed", dds_pkg::A_TXSPEED, 16'hFFFF, dds_pkg::RST_SPEED);
      rchk("tx empty", dds_pkg::A_STATUS, 16'h0001, 16'h0001);
      rchk("unmapped", 4'hF, 16'hFFFF, 16'h0000);
      rchk("rx speed", dds_pkg::A_RXSPEED, 16'hFFFF, dds_pkg::RST_SPEED);
      wr(dds_pkg::A_RXSPEED, 16'h0001);
      wr(dds_pkg::A_TXSPEED, 16'h0001);
      rchk("tx speed set", dds_pkg::A_TXSPEED, 16'hFFFF, 16'h0001);
      wr(dds_pkg::A_STARTCH, 16'h00A5);
      wr(dds_pkg::A_COUNT, 16'h0003);
      wr(dds_pkg::A_SYSADDR, 16'h1000);
      wr(dds_pkg::A_DATADDR, 16'h2000);
      wr(dds_pkg::A_CTRL, 16'h0003);
      $display("test setup done");
      // Transmit runs while the peer is sending
      wr(dds_pkg::A_TXDATA, 16'h0041);
      foreach (m1[i]) peer.send(m1[i]);
      wait_for(qn, 5);
      wait_for(n_dat, 1);
      check("sys 0", q[0], {1'b0, 16'h1000, 8'h11});
      check("sys 1", q[1], {1'b0, 16'h1001, 8'h22});
      check("data 0", q[2], {1'b1, 16'h2000, 8'h33});
      check("data 2", q[4], {1'b1, 16'h2002, 8'h55});
      check("sys irq", n_sys, 1);
      check("data irq", n_dat, 1);
      rchk("causes", dds_pkg::A_STATUS, 16'h0770, 16'h0240);
      check("tx char", peer.got, 8'h41);
      check("tx count", peer.got_n, 1);
      $display("test mixed done");
      peer.send(8'h66);
      wait_for(n_sys, 2);
      rchk("sys timeout", dds_pkg::A_STATUS, 16'h0070, 16'h0010);
      peer.send(8'hA5);
      peer.send(8'h77);
      rchk("in data", dds_pkg::A_STATUS, 16'h0008, 16'h0008);
      wait_for(n_dat, 2);
      rchk("data timeout", dds_pkg::A_STATUS, 16'h0700, 16'h0100);
      check("data restart", q[6], {1'b1, 16'h2000, 8'h77});
      $display("test timeout done");
      for (int i = 0; i < 256; i++) peer.send(i == 8'hA5 ? 8'h00 : 8'(i));
      wait_for(n_sys, 3);
      wait_for(qn, 263);
      check("last sys", q[262], {1'b0, 16'h10FF, 8'hFF});
      rchk("overflow", dds_pkg::A_STATUS, 16'h0070, 16'h0030);
      $display("test overflow done");
      stall <= 1'b1;
      b = qn;
      repeat (9) peer.send(8'h5A);
      rchk("overrun", dds_pkg::A_STATUS, 16'h0002, 16'h0002);
      stall <= 1'b0;
      wait_for(n_sys, 4);
      wait_for(qn, b + 8);
      repeat (20) @(posedge mclk);
      check("drained", qn, b + 8);
      wr(dds_pkg::A_STATUS, 16'h0000);
      rchk("overrun clear", dds_pkg::A_STATUS, 16'h0002, 16'h0000);
      $display("test fifo done");
      // Three stages fill up, so the fourth write must be dropped
      b = peer.got_n;
      for (int i = 0; i < 4; i++) wr(dds_pkg::A_TXDATA, 16'h0061 + 16'(i));
      rchk("tx full", dds_pkg::A_STATUS, 16'h0001, 16'h0000);
      repeat (600) @(posedge mclk);
      check("tx three", peer.got_n, b + 3);
      check("tx last", peer.got, 8'h63);
      $display("test tx store done");
      report_and_stop();
   end
endmodule
bind dds_top dds_top_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.mclk(mclk), .rst(rst),
   .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
   .txd_pin(txd_pin), .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_chan(dma_chan),
   .dma_addr(dma_addr), .dma_data(dma_data), .irq_sys(irq_sys), .irq_data(irq_data));
`default_nettype wire
